// file: rtl/svp_defs.svh
// offsets, reset values and field positions of the validity/parity bank
// assumes: included by bare name from the top module
`ifndef SVP_DEFS_SVH
`define SVP_DEFS_SVH

// register indices; the byte address is four times the index
`define SVP_IDX_AUX 16'hF69F
`define SVP_IDX_VL 16'hF6E0
`define SVP_IDX_VR 16'hF6F0
`define SVP_IDX_PL 16'hF700
`define SVP_IDX_PR 16'hF710
`define SVP_IDX_STAT 16'hF720

`define SVP_WORDS 12
`define SVP_FRAMES 192
`define SVP_RST_WORD 16'h0000
`define SVP_AUX_SEL_BIT 0
`define SVP_STAT_IDX_LSB 1
`define SVP_STAT_IDX_MSB 8

`endif

// file: rtl/svp_pkg.sv
// types shared by the validity/parity bank
// assumes: compiled before every module that imports it
package svp_pkg;

  // bus read sequence, gray coded except the DONE to IDLE step
  typedef enum logic [1:0] {
    SVP_RD_IDLE = 2'b00,
    SVP_RD_FETCH = 2'b01,
    SVP_RD_DONE = 2'b11
  } svp_rd_e;

  // arrays first so a bank value indexes the memory instances
  typedef enum logic [2:0] {
    SVP_BANK_VL = 3'h0,
    SVP_BANK_VR = 3'h1,
    SVP_BANK_PL = 3'h2,
    SVP_BANK_PR = 3'h3,
    SVP_BANK_AUX = 3'h4,
    SVP_BANK_STAT = 3'h5,
    SVP_BANK_NONE = 3'h7
  } svp_bank_e;

  typedef struct packed {
    svp_bank_e bank;
    logic [3:0] word;
  } svp_dec_s;

endpackage

// file: rtl/svp_word_mem.sv
// small word memory: one byte-masked write port, two registered read ports
// assumes: single clock, async active-low reset clears every word
`timescale 1ns/1ps
`default_nettype none

module svp_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 12,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH/8-1:0] wr_be_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] a_addr_i,
  output logic [WIDTH-1:0] a_data_o,
  input wire logic [AW-1:0] b_addr_i,
  output logic [WIDTH-1:0] b_data_o
);

  if (DEPTH > (1 << AW) || WIDTH % 8 != 0) begin : g_chk
    $error("svp_word_mem: DEPTH or WIDTH not served");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en_i && int'(wr_addr_i) < DEPTH) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
        if (wr_be_i[b]) begin
          mem_q[wr_addr_i][b*8 +: 8] <= wr_data_i[b*8 +: 8];
        end
      end
    end
  end

  // out-of-range reads return zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_data_o <= '0;
      b_data_o <= '0;
    end else begin
      a_data_o <= (int'(a_addr_i) < DEPTH) ? mem_q[a_addr_i] : '0;
      b_data_o <= (int'(b_addr_i) < DEPTH) ? mem_q[b_addr_i] : '0;
    end
  end

endmodule // svp_word_mem

`default_nettype wire

// file: rtl/svp_regs.sv
// validity and parity register bank of the s/pdif transmitter
// assumes: avalon-mm master with byte addresses, one clock at 250 mhz,
// frame encoder in the same clock domain asking one frame at a time
//
// Notes on behaviour
// - twelve rw 16-bit left validity words at indices F6E0..F6EB, reset zero.
// - twelve rw 16-bit right validity words at F6F0..F6FB, reset zero.
// - twelve rw 16-bit left parity words at indices F700..F70B, reset zero.
// - twelve rw 16-bit right parity words at indices F710..F71B, reset zero.
// - register bits go into frames only while the source select bit is zero.
// - select bit one makes frames carry the receiver's decoded bits instead.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "svp_defs.svh"

module svp_regs
  import svp_pkg::*;
#(
  parameter int WORDS = `SVP_WORDS,
  parameter int FRAMES = `SVP_FRAMES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // avalon-mm slave, byte address
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // frame encoder side
  input wire logic frm_req_i,
  input wire logic [7:0] frm_idx_i,
  input wire logic rx_validity_left_i,
  input wire logic rx_validity_right_i,
  input wire logic rx_parity_left_i,
  input wire logic rx_parity_right_i,
  output logic frm_valid_o,
  output logic tx_validity_left_o,
  output logic tx_validity_right_o,
  output logic tx_parity_left_o,
  output logic tx_parity_right_o,
  output logic aux_source_select_o
);

  if (WORDS < 1 || WORDS > 16 || FRAMES < 1 || FRAMES > WORDS * 16)
  begin : g_chk
    $error("svp_regs: WORDS or FRAMES not served");
  end

  localparam logic [15:0] WORDS_W = 16'(WORDS);
  localparam logic [8:0] FRAMES_W = 9'(FRAMES);

  function automatic logic in_bank(input logic [15:0] idx,
                                   input logic [15:0] base);
    return (idx >= base) && (idx < base + WORDS_W);
  endfunction

  // map a byte address onto a bank and a word within it
  function automatic svp_dec_s decode(input logic [17:0] addr);
    logic [15:0] idx;
    svp_dec_s d;
    idx = addr[17:2];
    d.bank = SVP_BANK_NONE;
    d.word = '0;
    if (in_bank(idx, `SVP_IDX_VL)) begin
      d.bank = SVP_BANK_VL;
      d.word = 4'(idx - `SVP_IDX_VL);
    end else if (in_bank(idx, `SVP_IDX_VR)) begin
      d.bank = SVP_BANK_VR;
      d.word = 4'(idx - `SVP_IDX_VR);
    end else if (in_bank(idx, `SVP_IDX_PL)) begin
      d.bank = SVP_BANK_PL;
      d.word = 4'(idx - `SVP_IDX_PL);
    end else if (in_bank(idx, `SVP_IDX_PR)) begin
      d.bank = SVP_BANK_PR;
      d.word = 4'(idx - `SVP_IDX_PR);
    end else if (idx == `SVP_IDX_AUX) begin
      d.bank = SVP_BANK_AUX;
    end else if (idx == `SVP_IDX_STAT) begin
      d.bank = SVP_BANK_STAT;
    end
    return d;
  endfunction

  svp_dec_s dec;
  svp_rd_e rd_q;
  svp_bank_e rd_bank_q;
  logic [15:0] aux_q;
  logic [7:0] last_idx_q;
  logic [15:0] mem_a_data [4];
  logic [15:0] mem_b_data [4];
  logic [15:0] stat_word;

  assign dec = decode(avs_address_i);
  assign aux_source_select_o = aux_q[`SVP_AUX_SEL_BIT];

  // status word: live source select and last frame index served
  always_comb begin
    stat_word = `SVP_RST_WORD;
    stat_word[`SVP_AUX_SEL_BIT] = aux_q[`SVP_AUX_SEL_BIT];
    stat_word[`SVP_STAT_IDX_MSB:`SVP_STAT_IDX_LSB] = last_idx_q;
  end

  // four arrays, each with a bus port and an encoder port
  for (genvar g = 0; g < 4; g++) begin : g_bank
    svp_word_mem #(
      .WIDTH(16),
      .DEPTH(WORDS),
      .AW(4)
    ) u_mem (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .wr_en_i(avs_write_i
               && dec.bank == svp_bank_e'(3'(g))),
      .wr_addr_i(dec.word),
      .wr_be_i(avs_byteenable_i[1:0]),
      .wr_data_i(avs_writedata_i[15:0]),
      .a_addr_i(dec.word),
      .a_data_o(mem_a_data[g]),
      .b_addr_i(frm_idx_i[7:4]),
      .b_data_o(mem_b_data[g])
    );
  end

  // writes take effect with no wait state; reads wait two cycles
  assign avs_waitrequest_o = avs_read_i && (rd_q != SVP_RD_DONE);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q <= SVP_RD_IDLE;
      rd_bank_q <= SVP_BANK_NONE;
    end else begin
      case (rd_q)
        SVP_RD_IDLE: begin
          if (avs_read_i) begin
            rd_q <= SVP_RD_FETCH;
            rd_bank_q <= dec.bank;
          end
        end
        SVP_RD_FETCH: rd_q <= SVP_RD_DONE;
        SVP_RD_DONE: rd_q <= SVP_RD_IDLE;
        default: rd_q <= SVP_RD_IDLE;
      endcase
    end
  end

  // read data come from a flop; unmapped reads return zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= '0;
    end else if (rd_q == SVP_RD_FETCH) begin
      case (rd_bank_q)
        SVP_BANK_VL: avs_readdata_o <= {16'h0000, mem_a_data[0]};
        SVP_BANK_VR: avs_readdata_o <= {16'h0000, mem_a_data[1]};
        SVP_BANK_PL: avs_readdata_o <= {16'h0000, mem_a_data[2]};
        SVP_BANK_PR: avs_readdata_o <= {16'h0000, mem_a_data[3]};
        SVP_BANK_AUX: avs_readdata_o <= {16'h0000, aux_q};
        SVP_BANK_STAT: avs_readdata_o <= {16'h0000, stat_word};
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  // source select register, reserved bits kept as written
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aux_q <= `SVP_RST_WORD;
    end else if (avs_write_i && dec.bank == SVP_BANK_AUX) begin
      if (avs_byteenable_i[0]) begin
        aux_q[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        aux_q[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // encoder pipeline: request at edge 0, bits valid after edge 1
  logic p1_vld_q;
  logic p1_inr_q;
  logic p1_sel_q;
  logic [3:0] p1_bit_q;
  logic [3:0] p1_rx_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p1_vld_q <= 1'b0;
      p1_inr_q <= 1'b0;
      p1_sel_q <= 1'b0;
      p1_bit_q <= '0;
      p1_rx_q <= '0;
      last_idx_q <= '0;
    end else begin
      p1_vld_q <= frm_req_i;
      if (frm_req_i) begin
        p1_inr_q <= {1'b0, frm_idx_i} < FRAMES_W;
        p1_sel_q <= aux_q[`SVP_AUX_SEL_BIT];
        p1_bit_q <= frm_idx_i[3:0];
        p1_rx_q <= {rx_parity_right_i, rx_parity_left_i,
                    rx_validity_right_i, rx_validity_left_i};
        last_idx_q <= frm_idx_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frm_valid_o <= 1'b0;
      tx_validity_left_o <= 1'b0;
      tx_validity_right_o <= 1'b0;
      tx_parity_left_o <= 1'b0;
      tx_parity_right_o <= 1'b0;
    end else begin
      frm_valid_o <= p1_vld_q;
      if (p1_vld_q) begin
        if (p1_sel_q) begin
          tx_validity_left_o <= p1_rx_q[0];
          tx_validity_right_o <= p1_rx_q[1];
          tx_parity_left_o <= p1_rx_q[2];
          tx_parity_right_o <= p1_rx_q[3];
        end else begin
          tx_validity_left_o <= p1_inr_q && mem_b_data[0][p1_bit_q];
          tx_validity_right_o <= p1_inr_q && mem_b_data[1][p1_bit_q];
          tx_parity_left_o <= p1_inr_q && mem_b_data[2][p1_bit_q];
          tx_parity_right_o <= p1_inr_q && mem_b_data[3][p1_bit_q];
        end
      end
    end
  end

endmodule // svp_regs

`default_nettype wire

// file: testbench/svp_regs_asserts.sv
// port checker for the validity/parity bank
// assumes: bound to svp_regs, one clock, reset low while active
`timescale 1ns/1ps
`default_nettype none
module svp_regs_asserts (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic frm_req_i,
  input wire logic rx_validity_left_i,
  input wire logic frm_valid_o,
  input wire logic tx_validity_left_o,
  input wire logic aux_source_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RD_WAIT: assert property ($rose(avs_read_i) |-> avs_waitrequest_o
    ##1 avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("read wait");
  AST_WR_NOWAIT: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  AST_RD_HIGH: assert property (avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read half set");
  AST_FRM_LAT: assert property (frm_req_i |-> ##2 frm_valid_o)
    else $error("frame answer late");
  AST_FRM_SRC: assert property (frm_valid_o |-> $past(frm_req_i, 2))
    else $error("frame answer unasked");
  AST_RX_PASS: assert property (frm_req_i && aux_source_select_o
    |-> ##2 tx_validity_left_o == $past(rx_validity_left_i, 2))
    else $error("receiver bit lost");
  AST_HOLD: assert property (!frm_valid_o
    |-> $stable(tx_validity_left_o)) else $error("frame bit moved");
  AST_SEL_WR: assert property (avs_write_i && avs_byteenable_i[0]
    && avs_address_i[17:2] == 16'hF69F
    |=> aux_source_select_o == $past(avs_writedata_i[0]))
    else $error("select not stored");
endmodule // svp_regs_asserts
bind svp_regs svp_regs_asserts u_chk (.clk_i, .arst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .frm_req_i, .rx_validity_left_i,
  .frm_valid_o, .tx_validity_left_o, .aux_source_select_o);
`default_nettype wire

// file: testbench/svp_enc_model.sv
// frame encoder model: one request per go pulse, captures the answer
// assumes: same clock as the bank, go pulse from the bench
`timescale 1ns/1ps
`default_nettype none
module svp_enc_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic go_i,
  input wire logic [7:0] idx_i,
  input wire logic [3:0] rx_i,
  input wire logic frm_valid_i,
  input wire logic [3:0] tx_i,
  output logic frm_req_o,
  output logic [7:0] frm_idx_o,
  output logic [3:0] rx_o,
  output logic [3:0] got_o
);
  // outside a request the lines toggle so stale values never match
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frm_req_o <= 1'b0;
      frm_idx_o <= 8'h00;
      rx_o <= 4'h0;
      got_o <= 4'h0;
    end else begin
      frm_req_o <= go_i;
      frm_idx_o <= go_i ? idx_i : ~frm_idx_o;
      rx_o <= go_i ? rx_i : ~rx_o;
      if (frm_valid_i) got_o <= tx_i;
    end
  end
endmodule // svp_enc_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the validity/parity bank
// assumes: avalon master tasks here, encoder model beside the bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0, arst_n_i = 1'b0, rd_r = 1'b0, wr_r = 1'b0, go = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [31:0] wdat = 32'h00000000, rdat, d;
  logic wreq, req, fv, sel;
  logic [7:0] fidx, gidx = 8'h00;
  logic [3:0] rx, grx = 4'h0, tx, got;
  int err_count = 0, checks_done = 0;
  logic [15:0] base [4] = '{16'hF6E0, 16'hF6F0, 16'hF700, 16'hF710};
  svp_regs dut (.clk_i, .arst_n_i, .avs_address_i(adr), .avs_read_i(rd_r),
    .avs_write_i(wr_r), .avs_byteenable_i(4'hF), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .frm_req_i(req),
    .frm_idx_i(fidx), .rx_validity_left_i(rx[3]),
    .rx_validity_right_i(rx[2]), .rx_parity_left_i(rx[1]),
    .rx_parity_right_i(rx[0]), .frm_valid_o(fv),
    .tx_validity_left_o(tx[3]), .tx_validity_right_o(tx[2]),
    .tx_parity_left_o(tx[1]), .tx_parity_right_o(tx[0]),
    .aux_source_select_o(sel));
  svp_enc_model u_enc (.clk_i, .arst_n_i, .go_i(go), .idx_i(gidx),
    .rx_i(grx), .frm_valid_i(fv), .tx_i(tx), .frm_req_o(req),
    .frm_idx_o(fidx), .rx_o(rx), .got_o(got));
  initial forever #2 clk_i = ~clk_i;
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] v);
    @(posedge clk_i);
    adr <= {i, 2'b00};
    wdat <= {16'h0000, v};
    wr_r <= 1'b1;
    @(posedge clk_i iff wreq === 1'b0);
    wr_r <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] i, output logic [31:0] v);
    @(posedge clk_i);
    adr <= {i, 2'b00};
    rd_r <= 1'b1;
    @(posedge clk_i iff wreq === 1'b0);
    v = rdat;
    rd_r <= 1'b0;
  endtask
  // frame answer lands a fixed four edges after go, checked on the fifth
  task automatic frm(input logic [7:0] i, input logic [3:0] r,
                     input logic [3:0] e);
    @(posedge clk_i);
    go <= 1'b1;
    gidx <= i;
    grx <= r;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("frame bits", {28'h0, e}, {28'h0, got});
  endtask
  initial begin
    repeat (2000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(base[i], d);
      chk("reset word", 32'h0, d);
      wr(base[i] + 16'h000B, 16'hA5C3 ^ 16'(i));
      wr(base[i] + 16'h0001, 16'h0004);
      rd(base[i] + 16'h000B, d);
      chk("last word", {16'h0, 16'hA5C3 ^ 16'(i)}, d);
    end
    wr(16'hF6EC, 16'hFFFF);
    rd(16'hF6EC, d);
    chk("unmapped", 32'h0, d);
    rd(16'hF69F, d);
    chk("select reset", 32'h0, d);
    frm(8'h12, 4'h0, 4'hF);
    frm(8'h11, 4'hF, 4'h0);
    frm(8'hBF, 4'h0, 4'hF);
    frm(8'hB0, 4'h5, 4'hA);
    // index past the block end carries no register bits
    frm(8'hC8, 4'hF, 4'h0);
    wr(16'hF69F, 16'h0001);
    frm(8'h12, 4'h5, 4'h5);
    frm(8'h12, 4'hA, 4'hA);
    chk("select out", 32'h1, {31'h0, sel});
    wr(16'hF69F, 16'h0000);
    frm(8'h12, 4'h5, 4'hF);
    // status is read-only: select 0, last index 0x12 in bits 8:1
    wr(16'hF720, 16'hFFFF);
    rd(16'hF720, d);
    chk("status", 32'h00000024, d);
    // mid-run reset must clear written words again
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(16'hF6EB, d);
    chk("word after reset", 32'h0, d);
    rd(16'hF69F, d);
    chk("select after reset", 32'h0, d);
    frm(8'hBF, 4'hF, 4'h0);
    finish_test();
  end
endmodule // tb
`default_nettype wire
